// ==== hw/interval_timer_watchdog.sv ====
// Interval timer, watchdog and Wishbone register slave
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
module interval_timer_watchdog (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        rc_clk_tick_i,
  input  wire logic        stop_i,
  input  wire logic        sub_clock_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             irq_o,
  output logic             dog_reset_o,
  output logic             reset_n_o,
  output logic             reset_n_oe_n_o,
  output logic             main_osc_enable_o,
  output logic             wake_tap_o,
  output logic             stop_halt_o
);
  import itw_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [10:0] presc_r;
  logic [7:0]  count_r;
  logic [7:0]  ctl_r;
  logic [7:0]  cmp_r;
  logic [6:0]  dog_r;
  logic [1:0]  status_r;
  logic [1:0]  mask_r;
  logic        armed_r;
  logic        ack_r;
  logic [31:0] rdat_r;
  logic        rst_pulse_r;
  logic        osc_on_r;

  function automatic logic [10:0] tap_mask(input logic [2:0] code);
    // Four-bit shift amount: codes 5 to 7 must not wrap past eight
    tap_mask = 11'((11'h001 << (4'(code) + 4'(DIV_BASE_SHIFT))) - 11'h001);
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  bus_req_type req;
  assign req = '{we: we_i, adr: adr_i, dat: dat_i[7:0], sel: sel_i[0]};
  wire access   = cyc_i & stb_i & ~ack_r;
  wire wr       = access & req.we & req.sel;
  wire wr_ctl   = wr & (req.adr == ADDR_INTERVAL);
  wire wr_cmp   = wr & (req.adr == ADDR_COMPARE);
  wire wr_st    = wr & (req.adr == ADDR_STATUS);
  wire wr_mask  = wr & (req.adr == ADDR_MASK);
  wire rc_stop  = stop_i & ctl_r[CTL_RCDOG_BIT];
  wire wake_stop = stop_i & ctl_r[CTL_WAKE_BIT] & ~rc_stop;
  // Plain stop halts everything; RC mode keeps counter running from RC
  wire [10:0] div_mask = tap_mask(ctl_r[2:0]);
  wire pulse_sys = ((presc_r & div_mask) == div_mask);
  // Counter source: RC ticks in RC stop, prescaler taps otherwise
  wire tick     = rc_stop ? rc_clk_tick_i : (~stop_i & pulse_sys);
  wire clr_int  = ctl_r[CTL_CLEAR_BIT];
  wire overflow = tick & ~clr_int & (count_r == 8'hFF);
  wire dog_on   = ~ctl_r[CTL_DOGRST_BIT] | armed_r;
  // RC tick is pre-divided by the counter, so dog steps on overflow too
  wire dog_step = overflow & dog_on;
  // Match on the step that reaches compare: period is compare intervals
  wire dog_match = (7'(dog_r + 7'h01) == cmp_r[6:0]) & dog_step;
  wire dog_clr  = cmp_r[CMP_CLEAR_BIT];
  wire fire_rst = dog_match & ctl_r[CTL_DOGRST_BIT];
  wire fire_irq = dog_match & ~ctl_r[CTL_DOGRST_BIT];
  wire [1:0] ev = {fire_irq, overflow};
  wire [31:0] rmux =
    (req.adr == ADDR_INTERVAL) ? {24'h000000, count_r} :
    (req.adr == ADDR_COMPARE)  ? {24'h000000, cmp_r} :
    (req.adr == ADDR_STATUS)   ? {30'h00000000, status_r} :
    (req.adr == ADDR_MASK)     ? {30'h00000000, mask_r} : 32'h00000000;

  // ----------------------------------------------------------------
  // Prescaler and interval counter
  // ----------------------------------------------------------------
  // Prescaler keeps running during wake stop for the 2048 tap
  always_ff @(posedge clk_i) begin
    if (rst_i | (stop_i & ~ctl_r[CTL_WAKE_BIT])) begin
      presc_r <= rst_i ? 11'h000 : presc_r;
    end else begin
      presc_r <= 11'(presc_r + 11'h001);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= 8'h00;
    end else if (clr_int) begin
      count_r <= 8'h00;
    end else if (tick & ~wake_stop) begin
      count_r <= 8'(count_r + 8'h01);
    end
  end

  // Control write; clear bits self-clear one cycle after setting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_r <= CTL_RESET;
    end else if (wr_ctl) begin
      ctl_r <= req.dat;
    end else begin
      ctl_r[CTL_CLEAR_BIT] <= 1'b0;
    end
  end

  // Compare reset value is arbitrary; software must program it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_r <= CMP_RESET;
    end else if (wr_cmp) begin
      cmp_r <= req.dat;
    end else begin
      cmp_r[CMP_CLEAR_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  // Arming waits for an interval clear after reset mode is selected
  always_ff @(posedge clk_i) begin
    if (rst_i | ~ctl_r[CTL_DOGRST_BIT]) begin
      armed_r <= 1'b0;
    end else if (clr_int) begin
      armed_r <= 1'b1;
    end
  end

  // Holds in plain stop because overflow never comes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dog_r <= 7'h00;
    end else if (dog_clr | dog_match) begin
      dog_r <= 7'h00;
    end else if (dog_step) begin
      dog_r <= 7'(dog_r + 7'h01);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_pulse_r <= 1'b0;
      osc_on_r    <= 1'b1;
    end else begin
      rst_pulse_r <= fire_rst;
      // Forced on by a dog reset until software leaves the sub clock
      osc_on_r    <= fire_rst | (osc_on_r & sub_clock_i);
    end
  end

  // ----------------------------------------------------------------
  // Status, mask and bus
  // ----------------------------------------------------------------
  // Set wins over write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= 2'b00;
      mask_r   <= 2'b00;
    end else begin
      status_r <= ev | (status_r & ~(wr_st ? req.dat[1:0] : 2'b00));
      if (wr_mask) begin
        mask_r <= req.dat[1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h00000000;
    end else begin
      ack_r  <= access;
      rdat_r <= access ? rmux : 32'h00000000;
    end
  end

  assign dat_o = rdat_r;
  assign ack_o = ack_r;
  assign irq_o = |(status_r & mask_r);
  assign dog_reset_o = rst_pulse_r;
  assign reset_n_o = 1'b0;
  assign reset_n_oe_n_o = ~rst_pulse_r;
  assign main_osc_enable_o = osc_on_r | ~sub_clock_i;
  assign wake_tap_o = (presc_r == WAKE_TAP_MASK);
  assign stop_halt_o = stop_i;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_wrap_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    overflow |=> status_r[ST_INTERVAL_BIT]) else $error("wrap lost");
  a_clear_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctl & req.dat[CTL_CLEAR_BIT] |=> ##1 count_r == 8'h00 && !clr_int)
    else $error("interval clear failed");
  a_dog_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_cmp & req.dat[CMP_CLEAR_BIT] |=> ##1 dog_r == 7'h00 && !dog_clr)
    else $error("dog clear failed");
  a_match_reset: assert property (
    @(posedge clk_i) disable iff (rst_i)
    fire_rst |=> dog_reset_o && !reset_n_oe_n_o) else $error("no reset");
  a_match_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    fire_irq |=> status_r[ST_DOG_BIT] && !dog_reset_o)
    else $error("no dog flag");
  a_dog_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    stop_i & ~ctl_r[CTL_RCDOG_BIT] & ~dog_clr |=> $stable(dog_r))
    else $error("dog moved in stop");
  a_count_step: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tick & ~clr_int & ~wake_stop |=> count_r == 8'($past(count_r) + 8'h01))
    else $error("count step wrong");
  a_unarmed: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl_r[CTL_DOGRST_BIT] & ~armed_r |-> !dog_step) else $error("dog early");

  // ----------------------------------------------------------------
  // Bus checks
  // ----------------------------------------------------------------
  // Answer comes exactly one cycle after the request is taken
  a_ack_answer: assert property (
    @(posedge clk_i) disable iff (rst_i)
    access |=> ack_o)
    else $error("no ack");

  a_ack_pulse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack too long");

  a_ack_idle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !cyc_i |=> !ack_o)
    else $error("ack without cycle");

  a_read_count: assert property (
    @(posedge clk_i) disable iff (rst_i)
    access & ~req.we & (req.adr == ADDR_INTERVAL)
    |=> dat_o == {24'h000000, $past(count_r)})
    else $error("counter read wrong");

  a_unmapped_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    access & (req.adr[7:4] != 4'hE) |=> dat_o == 32'h00000000)
    else $error("unmapped read not zero");

  a_ctl_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_ctl |=> ctl_r[2:0] == $past(req.dat[2:0]))
    else $error("control write lost");

  a_cmp_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_cmp |=> cmp_r[6:0] == $past(req.dat[6:0]))
    else $error("compare write lost");

  a_mask_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_mask |=> mask_r == $past(req.dat[1:0]))
    else $error("mask write lost");

  // ----------------------------------------------------------------
  // Interval timer checks
  // ----------------------------------------------------------------
  // A stuck clear bit would hold the counter at zero for ever
  a_clear_self: assert property (
    @(posedge clk_i) disable iff (rst_i)
    clr_int & ~wr_ctl |=> !clr_int)
    else $error("interval clear stuck");

  a_count_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ~tick & ~clr_int |=> $stable(count_r))
    else $error("counter moved without tick");

  a_wrap_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    overflow |=> count_r == 8'h00)
    else $error("wrap not to zero");

  a_status_sticky: assert property (
    @(posedge clk_i) disable iff (rst_i)
    status_r[ST_INTERVAL_BIT] & ~(wr_st & req.dat[0])
    |=> status_r[ST_INTERVAL_BIT])
    else $error("wrap flag lost");

  a_status_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_st & req.dat[0] & ~overflow |=> !status_r[ST_INTERVAL_BIT])
    else $error("wrap flag not cleared");

  a_presc_run: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ~stop_i |=> presc_r == 11'($past(presc_r) + 11'h001))
    else $error("prescaler step wrong");

  a_presc_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    stop_i & ~ctl_r[CTL_WAKE_BIT] |=> $stable(presc_r))
    else $error("prescaler ran in stop");

  a_stop_still: assert property (
    @(posedge clk_i) disable iff (rst_i)
    stop_i & ~ctl_r[CTL_RCDOG_BIT] |-> !tick)
    else $error("tick in stop");

  a_wake_count: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wake_stop & ~clr_int |=> $stable(count_r))
    else $error("counter ran in wake stop");

  a_tap_pulse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wake_tap_o & ~stop_i |=> !wake_tap_o)
    else $error("wake tap too long");

  a_rc_source: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rc_stop |-> tick == rc_clk_tick_i)
    else $error("RC tick not used");

  // ----------------------------------------------------------------
  // Watchdog checks
  // ----------------------------------------------------------------
  // Dog counter moves only on an interval overflow or a compare clear
  a_dog_step: assert property (
    @(posedge clk_i) disable iff (rst_i)
    dog_step & ~dog_clr & ~dog_match
    |=> dog_r == 7'($past(dog_r) + 7'h01))
    else $error("dog step wrong");

  a_dog_idle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ~dog_step & ~dog_clr |=> $stable(dog_r))
    else $error("dog moved without step");

  a_match_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    dog_match |=> dog_r == 7'h00)
    else $error("dog not restarted");

  a_cmp_self: assert property (
    @(posedge clk_i) disable iff (rst_i)
    dog_clr & ~wr_cmp |=> !dog_clr)
    else $error("dog clear stuck");

  a_arm_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ctl_r[CTL_DOGRST_BIT] & clr_int |=> armed_r)
    else $error("dog not armed");

  a_disarm: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ~ctl_r[CTL_DOGRST_BIT] |=> !armed_r)
    else $error("dog armed without reset mode");

  // ----------------------------------------------------------------
  // Output checks
  // ----------------------------------------------------------------
  // Reset pulse is one cycle; overflows are 256 ticks apart
  a_pulse_once: assert property (
    @(posedge clk_i) disable iff (rst_i)
    dog_reset_o |=> !dog_reset_o)
    else $error("reset pulse too long");

  a_osc_wake: assert property (
    @(posedge clk_i) disable iff (rst_i)
    fire_rst |=> main_osc_enable_o)
    else $error("oscillator not enabled");

  a_irq_dog: assert property (
    @(posedge clk_i) disable iff (rst_i)
    fire_irq & mask_r[ST_DOG_BIT] & ~wr_mask |=> irq_o)
    else $error("dog interrupt not raised");
endmodule

// ==== hw/itw_pkg.sv ====
// Constants, field layout and types for the interval timer and watchdog
package itw_pkg;
  // Byte addresses of the registers
  localparam logic [7:0] ADDR_INTERVAL = 8'hEC;
  localparam logic [7:0] ADDR_COMPARE  = 8'hE0;
  localparam logic [7:0] ADDR_STATUS   = 8'hE4;
  localparam logic [7:0] ADDR_MASK     = 8'hE8;
  // Control and compare register fields
  localparam int CTL_CLEAR_BIT   = 3;
  localparam int CTL_DOGRST_BIT  = 5;
  localparam int CTL_WAKE_BIT    = 6;
  localparam int CTL_RCDOG_BIT   = 7;
  localparam int CMP_CLEAR_BIT   = 7;
  // Status bits
  localparam int ST_INTERVAL_BIT = 0;
  localparam int ST_DOG_BIT      = 1;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET = 8'h7F;
  localparam logic [7:0] DIV_BASE_SHIFT = 8'h03;
  localparam logic [10:0] WAKE_TAP_MASK = 11'h7FF;
  localparam logic [7:0] RC_TICK_MASK = 8'hFF;
  // Bus request bundle
  typedef struct packed {
    logic       we;
    logic [7:0] adr;
    logic [7:0] dat;
    logic       sel;
  } bus_req_type;
endpackage

// ==== tb/cpu_side_model.sv ====
// Behavioural CPU side: stop level, RC ticks and reset bookkeeping
`timescale 1ns/1ps
module cpu_side_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       stop_req_i,
  input  wire logic       dog_reset_i,
  output logic            stop_o,
  output logic            rc_tick_o,
  output logic [7:0]      resets_o
);
  logic [1:0] div_r;
  // Free divider; a reset pulse from the dog is counted as one reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r    <= 2'h0;
      resets_o <= 8'h00;
    end else begin
      div_r <= div_r + 2'h1;
      if (dog_reset_i) begin
        resets_o <= resets_o + 8'h01;
      end
    end
  end
  // RC ticks only while stopped, so the crystal path sees none
  assign rc_tick_o = stop_o & (div_r == 2'h3);
  assign stop_o    = stop_req_i;
endmodule

// ==== tb/interval_timer_watchdog_tb.sv ====
// Self-checking bench for the interval timer and watchdog
`timescale 1ns/1ps
module interval_timer_watchdog_tb;
  import itw_pkg::*;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        sub_i = 0;
  logic        stp   = 0;
  logic        cyc   = 0;
  logic        stb   = 0;
  logic        we    = 0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wd    = 32'h0;
  logic [31:0] rd;
  logic        ack, irq, drst, rstn, oen, osc, tick, stop, halt, wtap;
  int          nwt = 0;
  int          wbase;
  logic [7:0]  q, nres, a;
  int          n_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          n;
  integer      seed = 32'h4CA5EA9C;

  always #5 clk_i = ~clk_i;

  interval_timer_watchdog interval_timer_watchdog_inst (
    .clk_i(clk_i), .rst_i(rst_i), .rc_clk_tick_i(tick), .stop_i(stop),
    .sub_clock_i(sub_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .dat_i(wd), .sel_i(4'h1), .dat_o(rd), .ack_o(ack),
    .irq_o(irq), .dog_reset_o(drst), .reset_n_o(rstn),
    .reset_n_oe_n_o(oen), .main_osc_enable_o(osc), .wake_tap_o(wtap),
    .stop_halt_o(halt));

  cpu_side_model cpu_side_model_inst (
    .clk_i(clk_i), .rst_i(rst_i), .stop_req_i(stp), .dog_reset_i(drst),
    .stop_o(stop), .rc_tick_o(tick), .resets_o(nres));

  // Wake tap pulses counted on the settled half of the cycle
  always @(negedge clk_i) begin
    if (wtap === 1'b1) begin
      nwt++;
    end
  end

  // Prescaler divide for a control code
  function automatic int dv(input int code);
    return 8 << code;
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One classic cycle; ack is watched at the falling edge, taken at rising
  task wb(input logic w, input logic [7:0] ad, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we  <= w;
    adr <= ad;
    wd  <= {24'h0, d};
    k = 0;
    @(negedge clk_i);
    while (ack !== 1'b1 && k < 20) begin
      @(negedge clk_i);
      k++;
    end
    chk(ack, 1);
    q = rd[7:0];
    @(posedge clk_i);
    cyc <= 0;
    stb <= 0;
    @(negedge clk_i);
  endtask

  // Bounded wait for the dog reset pulse (d=1) or the interrupt (d=0)
  task wt(input bit d, input int lim);
    n = 0;
    @(negedge clk_i);
    while ((d ? drst : irq) !== 1'b1 && n < lim) begin
      @(negedge clk_i);
      n++;
    end
  endtask

  task complete_run;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard; the whole run needs about 12500 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      complete_run;
    end
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    @(negedge clk_i);
    chk({irq, drst, oen, osc}, 4'b0011);
    wb(0, ADDR_INTERVAL, 8'h00);
    chk(q <= 1, 1);
    $display("reset test done");
    // Random unmapped places read zero and ignore writes
    repeat (4) begin
      a = 8'($random(seed)) & 8'h7F;
      wb(1, a, 8'($random(seed)));
      wb(0, a, 8'h00);
      chk(q, 0);
    end
    $display("map test done");
    // Every divide code, each started by an interval clear
    for (int c = 0; c < 8; c++) begin
      wb(1, ADDR_INTERVAL, 8'(c) | 8'h08);
      wb(0, ADDR_INTERVAL, 8'h00);
      chk(q <= 1, 1);
      repeat (dv(c) * 2) @(posedge clk_i);
      wb(0, ADDR_INTERVAL, 8'h00);
      chk(q == 2 || q == 3, 1);
    end
    $display("divide test done");
    wb(1, ADDR_STATUS, 8'h03);
    wb(1, ADDR_MASK, 8'h01);
    wb(1, ADDR_INTERVAL, 8'h08);
    chk(irq, 0);
    wt(0, 2100);
    chk(irq, 1);
    wb(1, ADDR_MASK, 8'h00);
    chk(irq, 0);
    wb(1, ADDR_STATUS, 8'h01);
    wb(0, ADDR_STATUS, 8'h00);
    chk(q[0], 0);
    // RC stop: counter follows the model's RC ticks, one per 4 clocks
    wb(1, ADDR_INTERVAL, 8'h88);
    @(posedge clk_i);
    stp <= 1;
    @(negedge clk_i);
    chk(halt, 1);
    repeat (64) @(posedge clk_i);
    stp <= 0;
    wb(0, ADDR_INTERVAL, 8'h00);
    chk(q >= 16 && q <= 18, 1);
    $display("overflow test done");
    // Dog match at two overflows raises the interrupt, not a reset
    wb(1, ADDR_COMPARE, 8'h82);
    wb(0, ADDR_COMPARE, 8'h00);
    chk(q, 8'h02);
    wb(1, ADDR_STATUS, 8'h03);
    wb(1, ADDR_MASK, 8'h02);
    wb(1, ADDR_INTERVAL, 8'h08);
    wbase = nwt;
    repeat (3072) @(posedge clk_i);
    chk(irq, 0);
    chk(nwt - wbase >= 1 && nwt - wbase <= 2, 1);
    wt(0, 2048);
    chk({irq, nres}, 9'h100);
    $display("dog interrupt test done");
    // Reset mode while on the sub clock
    @(posedge clk_i);
    sub_i <= 1;
    wb(1, ADDR_MASK, 8'h00);
    wb(1, ADDR_COMPARE, 8'h81);
    wb(1, ADDR_INTERVAL, 8'h28);
    chk(osc, 0);
    wt(1, 3000);
    chk({drst, oen, rstn}, 3'b100);
    @(negedge clk_i);
    chk({osc, nres}, 9'h101);
    $display("dog reset test done");
    complete_run;
  end
endmodule
